// ===== rtl/csas_map.vh
// Register map, field layout and reset values of the clock status and serial port clock block
`ifndef CSAS_MAP_VH
`define CSAS_MAP_VH

`define CSAS_ADDR_W         12
`define CSAS_OFF_MAIN_CFG   12'h100
`define CSAS_OFF_ASYNC_CFG  12'h104
`define CSAS_OFF_MAIN_TICK  12'h108
`define CSAS_OFF_ASYNC_TICK 12'h10C
`define CSAS_OFF_PORT_CFG   12'h110
`define CSAS_OFF_PORT_STS   12'h120
`define CSAS_PORT_STRIDE    12'h004
`define CSAS_OFF_CLK_STATUS 12'h160
`define CSAS_OFF_FAMILY     12'h164

// Domain configuration word
`define CSAS_CFG_FREQ       2:0
`define CSAS_CFG_SRC        6:3
`define CSAS_CFG_RATE       11:7
`define CSAS_CFG_RATE_FAM   11:10
`define CSAS_CFG_WMASK      32'h0000_0FFF
`define CSAS_CFG_RST        32'h0000_0000
`define CSAS_FAM_441        2'h1

// Domain sample tick period in pclk cycles
`define CSAS_TICK_WMASK     32'h0000_FFFF
`define CSAS_TICK_RST       16'h0200

// Serial port configuration word
`define CSAS_PC_HALF        7:0
`define CSAS_PC_HFRAME      15:8
`define CSAS_PC_BMST        16
`define CSAS_PC_LMST        17
`define CSAS_PC_DOM         18
`define CSAS_PC_WMASK       32'h0007_FFFF
`define CSAS_PC_RST         32'h0000_2004

// Serial port slip counters
`define CSAS_PS_DROP        7:0
`define CSAS_PS_REP         15:8
`define CSAS_CNT_MAX        8'hFF
`define CSAS_CNT_ONE        8'h01

// Clock domain status word
`define CSAS_ST_AFREQ       15:13
`define CSAS_ST_ASRC        12:9
`define CSAS_ST_MFREQ       6:4
`define CSAS_ST_MSRC        3:0
`define CSAS_ST_HI          31:16
`define CSAS_ST_GAP         8:7

`endif

// ===== rtl/csas_top.v
// Clock domain status register and serial port bit and frame clock control
//
// Contract
// [RULE_01] Async domain frequency code is read-only at status bits 15:13.
// [RULE_02] Async domain source code is read-only at status bits 12:9.
// [RULE_03] Main domain frequency code is read-only at status bits 6:4.
// [RULE_04] Main domain source code is read-only at status bits 3:0.
// [RULE_05] Async rate code 01XXX selects the 44.1 kHz frequency family.
// [RULE_06] Main rate code 01XXX selects the 44.1 kHz frequency family.
// [RULE_07] Master port generates and drives its bit clock and frame clock.
// [RULE_08] Slave port takes bit clock and frame clock from the host.
// [RULE_09] Bit clock and frame clock directions are chosen independently.
// [RULE_10] Port clocks are synchronised to their assigned main or async domain.
// [RULE_11] Host keeps a slave port's domain locked to the incoming frame clock.
// [RULE_12] An unlocked slave frame clock drops or repeats samples; count those slips.
// [RULE_13] Status register ignores writes and always shows the settings in effect.
`timescale 1ns/1ns
`include "csas_map.vh"

module csas_top #(
    parameter NP = 3
) (
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [`CSAS_ADDR_W-1:0] paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output wire                    pready,
    output wire                    pslverr,
    input  wire [NP-1:0]           serial_port_bit_clock_pin,
    output wire [NP-1:0]           serial_port_bit_clock_drive,
    output wire [NP-1:0]           serial_port_bit_clock_oe,
    input  wire [NP-1:0]           serial_port_frame_clock_pin,
    output wire [NP-1:0]           serial_port_frame_clock_drive,
    output wire [NP-1:0]           serial_port_frame_clock_oe,
    output wire [NP-1:0]           serial_port_slip
);

////////////////////////////////////////////////////////////////////////////////
// APB decode

wire        setup_ph  = psel & ~penable;
wire        access_ph = psel & penable;
wire        wr        = access_ph & pwrite;
wire [31:0] wmask_pc  = `CSAS_PC_WMASK;
wire [31:0] wmask_cfg = `CSAS_CFG_WMASK;
wire [31:0] wmask_tk  = `CSAS_TICK_WMASK;

wire hit_mcfg  = (paddr == `CSAS_OFF_MAIN_CFG);
wire hit_acfg  = (paddr == `CSAS_OFF_ASYNC_CFG);
wire hit_mtick = (paddr == `CSAS_OFF_MAIN_TICK);
wire hit_atick = (paddr == `CSAS_OFF_ASYNC_TICK);
wire hit_stat  = (paddr == `CSAS_OFF_CLK_STATUS);
wire hit_fam   = (paddr == `CSAS_OFF_FAMILY);

wire [NP-1:0]    hit_pcfg;
wire [NP-1:0]    hit_psts;
wire [32*NP-1:0] pcfg_all;
wire [32*NP-1:0] psts_all;

wire mapped = hit_mcfg | hit_acfg | hit_mtick | hit_atick | hit_stat | hit_fam
              | (|hit_pcfg) | (|hit_psts);

// Every register answers in its first access cycle, so no wait states are inserted
assign pready  = 1'b1;
// Unmapped offsets complete with pslverr set; writes there are dropped and reads return zero
assign pslverr = access_ph & ~mapped;

////////////////////////////////////////////////////////////////////////////////
// Domain configuration and sample ticks

reg [31:0] main_cfg_r;
reg [31:0] async_cfg_r;
reg [15:0] main_period_r;
reg [15:0] async_period_r;
reg [15:0] main_cnt_r;
reg [15:0] async_cnt_r;

// A zero period acts as one tick per cycle rather than wrapping to the top count
wire [15:0] main_lim  = (main_period_r == 16'h0000) ? 16'h0000 : main_period_r - 16'h0001;
wire [15:0] async_lim = (async_period_r == 16'h0000) ? 16'h0000 : async_period_r - 16'h0001;

// Compare with >= so a period shortened below the running count ticks at once
wire main_tick  = (main_cnt_r >= main_lim);
wire async_tick = (async_cnt_r >= async_lim);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        main_cfg_r     <= `CSAS_CFG_RST;
        async_cfg_r    <= `CSAS_CFG_RST;
        main_period_r  <= `CSAS_TICK_RST;
        async_period_r <= `CSAS_TICK_RST;
    end else begin
        // Only the defined configuration bits are stored
        if (wr && hit_mcfg) begin
            main_cfg_r <= pwdata & wmask_cfg;
        end
        if (wr && hit_acfg) begin
            async_cfg_r <= pwdata & wmask_cfg;
        end
        if (wr && hit_mtick) begin
            main_period_r <= pwdata[15:0] & wmask_tk[15:0];
        end
        if (wr && hit_atick) begin
            async_period_r <= pwdata[15:0] & wmask_tk[15:0];
        end
    end
end

// Free-running sample ticks stand in for the two domain sample clocks
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        main_cnt_r  <= 16'h0000;
        async_cnt_r <= 16'h0000;
    end else begin
        main_cnt_r  <= main_tick ? 16'h0000 : main_cnt_r + 16'h0001;
        async_cnt_r <= async_tick ? 16'h0000 : async_cnt_r + 16'h0001;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Clock domain status

// Fields track the configuration live; there is no write path
wire [31:0] clk_status;
// Reserved codes pass through as written; nothing filters them
assign clk_status[`CSAS_ST_HI]    = 16'h0000;
assign clk_status[`CSAS_ST_AFREQ] = async_cfg_r[`CSAS_CFG_FREQ];  // RULE_01
assign clk_status[`CSAS_ST_ASRC]  = async_cfg_r[`CSAS_CFG_SRC];   // RULE_02
assign clk_status[`CSAS_ST_GAP]   = 2'h0;
assign clk_status[`CSAS_ST_MFREQ] = main_cfg_r[`CSAS_CFG_FREQ];   // RULE_03
assign clk_status[`CSAS_ST_MSRC]  = main_cfg_r[`CSAS_CFG_SRC];    // RULE_04

// Bit 1 set: async codes read as 44.1 kHz family; bit 0 likewise for main
wire async_fam441 = (async_cfg_r[`CSAS_CFG_RATE_FAM] == `CSAS_FAM_441);  // RULE_05
wire main_fam441  = (main_cfg_r[`CSAS_CFG_RATE_FAM] == `CSAS_FAM_441);   // RULE_06
wire [31:0] fam_status = {30'h0000_0000, async_fam441, main_fam441};

////////////////////////////////////////////////////////////////////////////////
// Serial ports

genvar i;
generate
    for (i = 0; i < NP; i = i + 1) begin : g_port
        // Offsets are worked out at full width, then cut to the bus address width
        localparam integer A_CFG_FULL = `CSAS_OFF_PORT_CFG + `CSAS_PORT_STRIDE * i;
        localparam integer A_STS_FULL = `CSAS_OFF_PORT_STS + `CSAS_PORT_STRIDE * i;
        localparam [`CSAS_ADDR_W-1:0] A_CFG = A_CFG_FULL[`CSAS_ADDR_W-1:0];
        localparam [`CSAS_ADDR_W-1:0] A_STS = A_STS_FULL[`CSAS_ADDR_W-1:0];

        reg [31:0] cfg_r;
        reg        b_s1_r;
        reg        b_s2_r;
        reg        b_s3_r;
        reg        l_s1_r;
        reg        l_s2_r;
        reg [7:0]  div_r;
        reg        bgen_r;
        reg [7:0]  bits_r;
        reg        lgen_r;
        reg        lprev_r;
        reg [1:0]  ticks_r;
        reg [7:0]  drop_r;
        reg [7:0]  rep_r;
        reg        slip_r;

        assign hit_pcfg[i] = (paddr == A_CFG);
        assign hit_psts[i] = (paddr == A_STS);
        assign pcfg_all[32*i +: 32] = cfg_r;
        assign psts_all[32*i +: 32] = {16'h0000, rep_r, drop_r};

        wire       bmst  = cfg_r[`CSAS_PC_BMST];
        wire       lmst  = cfg_r[`CSAS_PC_LMST];
        wire       tick  = cfg_r[`CSAS_PC_DOM] ? async_tick : main_tick;  // RULE_10
        wire [7:0] half  = (cfg_r[`CSAS_PC_HALF] == 8'h00) ? 8'h01 : cfg_r[`CSAS_PC_HALF];
        wire [7:0] hfrm  = (cfg_r[`CSAS_PC_HFRAME] == 8'h00) ? 8'h01 : cfg_r[`CSAS_PC_HFRAME];
        wire       btgl  = (div_r >= half - 8'h01);
        // Falling bit clock edge from the generator or from the synchronised pin
        wire       bfall = bmst ? (btgl & bgen_r) : (b_s3_r & ~b_s2_r);  // RULE_09
        wire       lnow  = lmst ? lgen_r : l_s2_r;                         // RULE_09
        wire       lrise = lnow & ~lprev_r;
        wire       frm_restart = lmst & tick;
        // The first rise after a mode change may report one spurious slip
        wire       chk   = lrise & ~lmst;
        wire [1:0] seen  = (ticks_r == 2'h2) ? 2'h2 : ticks_r + {1'b0, tick};
        wire       drop  = chk & (seen == 2'h0);                           // RULE_12
        wire       rep   = chk & (seen == 2'h2);                           // RULE_12
        wire       sclr  = wr & hit_psts[i];

        assign serial_port_bit_clock_drive[i]   = bgen_r;                  // RULE_07
        assign serial_port_bit_clock_oe[i]      = bmst;                    // RULE_07 RULE_08
        assign serial_port_frame_clock_drive[i] = lgen_r;                  // RULE_07
        assign serial_port_frame_clock_oe[i]    = lmst;                    // RULE_07 RULE_08
        assign serial_port_slip[i]              = slip_r;

        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg_r <= `CSAS_PC_RST;
            end else if (wr && hit_pcfg[i]) begin
                cfg_r <= pwdata & wmask_pc;
            end
        end

        // Pin inputs pass two flops before any logic reads them
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                b_s1_r <= 1'b0;
                b_s2_r <= 1'b0;
                b_s3_r <= 1'b0;
                l_s1_r <= 1'b0;
                l_s2_r <= 1'b0;
            end else begin
                // The third bit clock flop only feeds the falling edge detector
                b_s1_r <= serial_port_bit_clock_pin[i];                    // RULE_08
                b_s2_r <= b_s1_r;
                b_s3_r <= b_s2_r;
                l_s1_r <= serial_port_frame_clock_pin[i];                  // RULE_08
                l_s2_r <= l_s1_r;
            end
        end

        // Bit and frame generators; a master frame restarts on each domain tick
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                div_r  <= 8'h00;
                bgen_r <= 1'b0;
                bits_r <= 8'h00;
                lgen_r <= 1'b0;
            end else if (frm_restart) begin                                // RULE_10
                div_r  <= 8'h00;
                bgen_r <= 1'b0;
                bits_r <= 8'h00;
                lgen_r <= 1'b1;
            end else begin
                div_r  <= btgl ? 8'h00 : div_r + 8'h01;
                bgen_r <= btgl ? ~bgen_r : bgen_r;                         // RULE_07
                // In mixed mode the frame counts falls of the incoming bit clock
                if (bfall) begin
                    if (bits_r >= hfrm - 8'h01) begin
                        bits_r <= 8'h00;
                        lgen_r <= ~lgen_r;                                 // RULE_07
                    end else begin
                        bits_r <= bits_r + 8'h01;
                    end
                end
            end
        end

        // Domain ticks seen per incoming frame: none is a drop, two or more a repeat
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lprev_r <= 1'b0;
                ticks_r <= 2'h0;
                slip_r  <= 1'b0;
            end else begin
                lprev_r <= lnow;
                ticks_r <= lrise ? 2'h0 : seen;
                slip_r  <= drop | rep;                                     // RULE_12
            end
        end

        // Saturating slip counters; a slip in the clearing cycle still counts
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                drop_r <= 8'h00;
                rep_r  <= 8'h00;
            end else begin
                if (sclr) begin
                    drop_r <= drop ? `CSAS_CNT_ONE : 8'h00;
                end else if (drop && drop_r != `CSAS_CNT_MAX) begin
                    drop_r <= drop_r + 8'h01;                              // RULE_12
                end
                if (sclr) begin
                    rep_r <= rep ? `CSAS_CNT_ONE : 8'h00;
                end else if (rep && rep_r != `CSAS_CNT_MAX) begin
                    rep_r <= rep_r + 8'h01;                                // RULE_12
                end
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Read data, captured in the setup phase

reg [31:0] rd_mux;
integer    k;

always @* begin
    rd_mux = 32'h0000_0000;
    if (hit_mcfg) begin
        rd_mux = main_cfg_r;
    end
    if (hit_acfg) begin
        rd_mux = async_cfg_r;
    end
    if (hit_mtick) begin
        rd_mux = {16'h0000, main_period_r};
    end
    if (hit_atick) begin
        rd_mux = {16'h0000, async_period_r};
    end
    if (hit_stat) begin
        rd_mux = clk_status;                                               // RULE_13
    end
    if (hit_fam) begin
        rd_mux = fam_status;
    end
    // Port words decode last; their offsets never overlap the fixed ones
    for (k = 0; k < NP; k = k + 1) begin
        if (hit_pcfg[k]) begin
            rd_mux = pcfg_all[32*k +: 32];
        end
        if (hit_psts[k]) begin
            rd_mux = psts_all[32*k +: 32];
        end
    end
end

// Loading at setup keeps prdata steady through the whole access phase
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
        prdata <= rd_mux;
    end
end

endmodule

// ===== sim/csas_props.sv
// Port-level checker for the clock status and serial port clock block
`timescale 1ns/1ns
module csas_props #(
    parameter NP = 3
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pslverr,
    input wire logic [NP-1:0] serial_port_bit_clock_drive,
    input wire logic [NP-1:0] serial_port_bit_clock_oe,
    input wire logic [NP-1:0] serial_port_frame_clock_oe,
    input wire logic [NP-1:0] serial_port_slip
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    assign acc = psel && penable;

    a_err_phase: assert property (pslverr |-> acc)
        else $error("error flag outside access phase");
    a_status_noerr: assert property (acc && paddr == 12'h160 |-> !pslverr)
        else $error("status access flagged as error");
    a_status_unused: assert property (acc && !pwrite && paddr == 12'h160 |->
        prdata[31:16] == 16'h0000 && prdata[8:7] == 2'b00)
        else $error("status unused bits not zero");
    a_status_live: assert property (acc && pwrite && paddr == 12'h100 ##2
        psel && !penable && !pwrite && paddr == 12'h160
        |=> prdata[6:0] == {$past(pwdata[2:0], 3), $past(pwdata[6:3], 3)})
        else $error("status does not follow main setting");
    a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    a_bclk_dir: assert property (!$stable(serial_port_bit_clock_oe)
        |-> $past(acc && pwrite))
        else $error("bit clock direction changed without a write");
    a_lclk_dir: assert property (!$stable(serial_port_frame_clock_oe)
        |-> $past(acc && pwrite))
        else $error("frame clock direction changed without a write");
    a_bclk_runs: assert property (serial_port_bit_clock_oe[0]
        |-> ##[0:300] $changed(serial_port_bit_clock_drive[0]))
        else $error("master bit clock not toggling");
    a_slip_pulse: assert property (serial_port_slip[0] |=> !serial_port_slip[0])
        else $error("slip pulse longer than one cycle");
endmodule
bind csas_top csas_props #(.NP(NP)) chk_u (.*);

// ===== sim/csas_host.sv
// Behavioural far-side host driving a slave port's bit and frame clocks
`timescale 1ns/1ns
module csas_host (
    input  wire logic       run,
    input  wire logic [7:0] nbits,
    output logic            bclk,
    output logic            lclk
);
    int k;
    initial begin
        bclk = 1'b0;
        lclk = 1'b0;
        #3;
        forever begin
            if (!run) begin
                #10; // Clocks stand still while run is low; edges stay clear of pclk
            end else begin
                for (k = 0; k < nbits; k++) begin
                    #40 bclk = 1'b1;
                    #40 bclk = 1'b0;
                end
                lclk = ~lclk;
            end
        end
    end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the clock status and serial port clock block
`timescale 1ns/1ns
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, run, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, mv, av;
    logic [7:0]  nbits;
    int          bad_count, n_compared, i, p, m, h, lk, sc;
    wire  [31:0] prdata;
    wire         pready, pslverr, hb, hl;
    wire  [2:0]  bo, bd, lo, ld, slip, bpin, lpin;
    // Pin level: device drive when enabled, else host clock
    assign bpin = (bo & bd) | (~bo & {3{hb}});
    assign lpin = (lo & ld) | (~lo & {3{hl}});
    csas_top #(.NP(3)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_port_bit_clock_pin(bpin), .serial_port_bit_clock_drive(bd),
        .serial_port_bit_clock_oe(bo), .serial_port_frame_clock_pin(lpin),
        .serial_port_frame_clock_drive(ld), .serial_port_frame_clock_oe(lo),
        .serial_port_slip(slip));
    csas_host host_u (.run(run), .nbits(nbits), .bclk(hb), .lclk(hl));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("bad_count=%0d n_compared=%0d", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (pready !== 1'b1) begin
            bad_count++;
            conclude;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic half(input int q, input int e, input bit fr);
        int t;
        logic b;
        for (int s = 0; s < 2; s++) begin
            b = fr ? ld[q] : bd[q];
            t = 0;
            while ((fr ? ld[q] : bd[q]) === b && t < 80) begin
                @(posedge pclk);
                t++;
            end
        end
        chk(t, e);
    endtask
    function automatic logic [31:0] exp_sts(input logic [31:0] a, input logic [31:0] b);
        return {16'h0000, b[2:0], b[6:3], 2'b00, a[2:0], a[6:3]};
    endfunction
    function automatic logic [31:0] exp_slip(input int t, input int l);
        return {30'h0, t > l, t < l}; // Sparse ticks drop, dense ticks repeat
    endfunction
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, run} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        nbits = 8'h08;
        void'($urandom(71));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'h160, 0);
        chk(rd, 32'h0000_0000);
        apb(0, 12'h110, 0);
        chk(rd, 32'h0000_2004);
        apb(0, 12'h1FC, 0);
        chk({rd[30:0], er}, 32'h0000_0001);
        for (i = 0; i < 6; i++) begin
            mv = $urandom & 32'h0000_0FFF;
            av = $urandom & 32'h0000_0FFF;
            if (i == 0) mv[11:10] = 2'b01;
            if (i == 1) av[11:10] = 2'b01;
            apb(1, 12'h104, av);
            apb(1, 12'h100, mv);
            apb(0, 12'h160, 0);
            chk(rd, exp_sts(mv, av));
            apb(1, 12'h160, $urandom);
            chk({31'h0, er}, 32'h0000_0000);
            apb(0, 12'h160, 0);
            chk(rd, exp_sts(mv, av));
            apb(0, 12'h164, 0);
            chk(rd, {30'h0, av[11:10] == 2'b01, mv[11:10] == 2'b01});
        end
        nbits <= 8'($urandom_range(4, 12));
        run <= 1'b1;
        @(posedge pclk);
        lk = 16 * nbits;
        for (i = 0; i < 4; i++) begin
            p = (i == 1) ? lk / 2 : (i == 2) ? lk * 2 : lk;
            apb(1, 12'h108, (i == 3) ? lk / 2 : p);
            apb(1, 12'h10C, p);
            apb(1, 12'h110, {13'h0, i == 3, 18'h0_2004});
            repeat (5 * lk) @(posedge pclk);
            apb(1, 12'h120, 0);
            sc = 0;
            repeat (12 * lk) begin
                @(posedge pclk);
                sc += slip[0];
            end
            apb(0, 12'h120, 0);
            chk({30'h0, rd[7:0] != 0, rd[15:8] != 0}, exp_slip(p, lk));
            chk({31'h0, sc != 0}, {31'h0, p != lk});
        end
        run <= 1'b0;
        apb(1, 12'h108, 32'h0000_FFFF);
        for (i = 0; i < 12; i++) begin
            m = i % 4;
            p = i / 4;
            h = $urandom_range(1, 8);
            apb(1, 12'(12'h110 + 4 * p), {14'h0, m[1:0], 8'h02, h[7:0]});
            chk({30'h0, lo[p], bo[p]}, m);
            if (m[0]) half(p, h, 1'b0);
            if (m == 3) half(p, 4 * h, 1'b1);
        end
        conclude;
    end
endmodule
